// ---- bench/drs_assertions.sv ----
// Port-level checks of the RAM profile sequencer.
module drs_assertions
  import drs_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        CS_N,
  input wire logic        IO_UPDATE,
  input wire logic [1:0]  PROFILE_SELECT_PINS,
  input wire logic [31:0] TUNING_WORD,
  input wire logic [13:0] PHASE_OFFSET,
  input wire logic        PHASE_ACC_CLEAR,
  input wire logic        MEM_LOAD_BUSY
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] pins_q;
  logic [7:0] quiet_q;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) pins_q <= 2'h0;
    else pins_q <= PROFILE_SELECT_PINS;
  end

  // Saturates so a long quiet spell never wraps back into the window.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) quiet_q <= 8'h00;
    else if (IO_UPDATE || PROFILE_SELECT_PINS != pins_q) quiet_q <= 8'h00;
    else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
  end

  reset_clean_a:
    assert property ($fell(RST) |-> TUNING_WORD == 32'h0 && PHASE_OFFSET == 14'h0
      && !PHASE_ACC_CLEAR && !MEM_LOAD_BUSY) else $error("outputs not clear after reset");
  busy_in_frame_a:
    assert property ($rose(MEM_LOAD_BUSY) |-> !CS_N) else $error("load busy outside a frame");
  busy_ends_a:
    assert property ($rose(CS_N) |-> ##[1:8] !MEM_LOAD_BUSY) else $error("load busy stuck");
  busy_idle_a:
    assert property (CS_N [*8] |-> !MEM_LOAD_BUSY) else $error("load busy while idle");
  read_frozen_a:
    assert property (MEM_LOAD_BUSY [*2] |-> $stable(TUNING_WORD) && $stable(PHASE_OFFSET))
      else $error("outputs moved during a load");
  clear_upd_a:
    assert property (PHASE_ACC_CLEAR && $rose(IO_UPDATE) |-> ##[1:10] !PHASE_ACC_CLEAR)
      else $error("clear kept after update");
  clear_prof_a:
    assert property (PHASE_ACC_CLEAR && PROFILE_SELECT_PINS != pins_q |-> ##[1:10]
      !PHASE_ACC_CLEAR) else $error("clear kept after profile change");
  clear_hold_a:
    assert property ($fell(PHASE_ACC_CLEAR) |-> quiet_q < 8'h0c)
      else $error("clear dropped without a start");
endmodule : drs_assertions

bind drs_ram_profile_sequencer drs_assertions u_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .CS_N(CS_N), .IO_UPDATE(IO_UPDATE),
  .PROFILE_SELECT_PINS(PROFILE_SELECT_PINS), .TUNING_WORD(TUNING_WORD),
  .PHASE_OFFSET(PHASE_OFFSET), .PHASE_ACC_CLEAR(PHASE_ACC_CLEAR),
  .MEM_LOAD_BUSY(MEM_LOAD_BUSY));

// ---- bench/drs_host_model.sv ----
// Host side of the serial link, sending whole frames on its own clock.
module drs_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdio
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio = 1'b1;
  end

  // The link clock stands still between frames; idle data shows the inverse of its last bit.
  task automatic send(input logic [7:0] b[$]);
    #1.3;
    cs_n = 1'b0;
    foreach (b[i]) for (int k = 7; k >= 0; k--) begin
      sdio = b[i][k];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    sdio = ~sdio;
    #30;
  endtask : send
endmodule : drs_host_model

// ---- bench/test_drs_ram_profile_sequencer.sv ----
// Self-checking bench for the RAM profile sequencer.
module test_drs_ram_profile_sequencer
  import drs_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [1:0]  p;
    logic [31:0] tw;
    logic [13:0] ph;
  } drs_tb_row_t;

  localparam logic [31:0] T0  = 32'h1234_5678;
  localparam logic [13:0] P0  = 14'h1abc;
  localparam logic [31:0] EN  = 32'h1 << MEM_ENABLE_BIT;
  localparam logic [31:0] DST = 32'h1 << MEM_DEST_BIT;
  localparam logic [31:0] SWP = 32'h1 << LIN_SWEEP_BIT;
  localparam logic [9:0]  BEG [4] = '{10'h104, 10'h2c0, 10'h0c8, 10'h3f0};
  localparam logic [9:0]  FIN [4] = '{10'h106, 10'h2c0, 10'h0c8, 10'h3f2};
  localparam logic [2:0]  MODE [4] = '{3'h1, 3'h0, 3'h5, 3'h1};
  localparam logic [15:0] RATE [4] = '{16'h000a, 16'h0001, 16'h0001, 16'h0008};
  localparam logic        ND [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  logic        core_clk;
  logic        rst;
  logic        io_update;
  logic [1:0]  pins;
  logic        sclk;
  logic        cs_n;
  logic        sdio;
  logic [31:0] tw;
  logic [13:0] ph;
  logic        acc_clr;
  logic        busy;
  logic [31:0] x;
  int          n_errors;
  int          tests_run;
  int          cycles = 0;
  int          n;

  function automatic logic [31:0] mw(input logic [9:0] a);
    return {a, 12'h5a3, a};
  endfunction : mw

  function automatic logic [13:0] mp(input logic [9:0] a);
    logic [31:0] w;
    w = mw(a);
    return w[31:18];
  endfunction : mp

  function automatic logic [39:0] seg(input int p);
    return {RATE[p], FIN[p][7:0], BEG[p][5:0], FIN[p][9:8], MODE[p], ND[p], BEG[p][9:6]};
  endfunction : seg

  localparam drs_tb_row_t ROWS [5] = '{'{32'h0, 2'h1, T0, P0}, '{EN, 2'h1, mw(10'h2c0), P0},
    '{EN, 2'h2, mw(10'h0c8), P0}, '{EN | DST, 2'h1, T0, mp(10'h2c0)},
    '{EN | DST, 2'h2, T0, mp(10'h0c8)}};

  drs_host_model host (.sclk(sclk), .cs_n(cs_n), .sdio(sdio));

  drs_ram_profile_sequencer dut (
    .CORE_CLK(core_clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SDIO(sdio),
    .IO_UPDATE(io_update), .PROFILE_SELECT_PINS(pins), .TUNING_WORD(tw),
    .PHASE_OFFSET(ph), .PHASE_ACC_CLEAR(acc_clr), .MEM_LOAD_BUSY(busy));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [39:0] v, input int nb);
    logic [7:0] q[$];
    q = '{{3'h0, a}};
    for (int i = nb - 1; i >= 0; i--) q.push_back(v[8*i +: 8]);
    host.send(q);
    repeat (8) @(posedge core_clk);
  endtask : wr

  // The segment is chosen on the pins before the load instruction goes out.
  task automatic ld(input int p);
    logic [7:0]  q[$];
    logic [31:0] w;
    @(posedge core_clk) pins <= 2'(p);
    repeat (6) @(posedge core_clk);
    q = '{{3'h0, ADDR_WAVE_MEM}};
    for (int a = BEG[p]; a <= FIN[p]; a++) begin
      w = mw(10'(a));
      for (int i = 3; i >= 0; i--) q.push_back(w[8*i +: 8]);
    end
    host.send(q);
  endtask : ld

  task automatic upd();
    @(posedge core_clk) io_update <= 1'b1;
    repeat (2) @(posedge core_clk);
    io_update <= 1'b0;
  endtask : upd

  task automatic wt(input logic [31:0] v, output int k);
    k = 0;
    @(negedge core_clk);
    while (tw !== v && k < 3000) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 3000) chk(tw, v);
  endtask : wt

  initial begin
    n_errors = 0;
    tests_run = 0;
    rst = 1'b1;
    io_update = 1'b0;
    pins = 2'h0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk(tw, 32'h0);
    chk({16'h0, ph, acc_clr, busy}, 32'h0);
    repeat (3) @(posedge core_clk);
    wr(ADDR_TUNING0, {8'h0, T0}, 4);
    chk(tw, 32'h0);
    wr(ADDR_PHASE_OFS, {26'h0, P0}, 2);
    for (int p = 0; p < 4; p++) wr(ADDR_SEG0 + 5'(p), seg(p), 5);
    upd();
    for (int p = 0; p < 4; p++) ld(p);
    chk({31'h0, busy}, 32'h0);
    foreach (ROWS[r]) begin
      wr(ADDR_MAIN_CTRL, {8'h0, ROWS[r].ctrl}, 4);
      @(posedge core_clk) pins <= ROWS[r].p;
      upd();
      repeat (12) @(negedge core_clk);
      chk(tw, ROWS[r].tw);
      chk({18'h0, ph}, {18'h0, ROWS[r].ph});
    end
    wr(ADDR_MAIN_CTRL, {8'h0, EN}, 4);
    @(posedge core_clk) pins <= 2'h0;
    upd();
    // The first dwell can run a cycle long when the pin change and the update restart apart.
    wt(mw(BEG[0]), n);
    wt(mw(BEG[0] + 10'h1), n);
    wt(mw(FIN[0]), n);
    chk(n, 32'(RATE[0]) - 1);
    repeat (40) @(negedge core_clk);
    chk(tw, mw(FIN[0]));
    chk({31'h0, acc_clr}, 32'h0);
    upd();
    ld(0);
    @(posedge core_clk) pins <= 2'h3;
    wt(mw(FIN[3]), n);
    n = 0;
    while (acc_clr !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk({31'h0, n >= int'(RATE[3]) - 2 && n <= int'(RATE[3])}, 32'h1);
    repeat (5) @(negedge core_clk);
    chk(tw, mw(BEG[3]));
    upd();
    repeat (60) @(negedge core_clk);
    chk({31'h0, acc_clr}, 32'h1);
    @(posedge core_clk) pins <= 2'h0;
    repeat (20) @(negedge core_clk);
    chk({31'h0, acc_clr}, 32'h0);
    wr(ADDR_SEG0 + 5'h1, {8'h04, 32'h0000_1000}, 5);
    wr(ADDR_SEG0, {8'h03, 32'h0000_0100}, 5);
    wr(ADDR_MAIN_CTRL, {8'h0, SWP}, 4);
    @(posedge core_clk) pins <= 2'h1;
    upd();
    wt(T0 + 32'h1000, n);
    wt(T0 + 32'h2000, n);
    chk(n, 32'h3);
    @(posedge core_clk) pins <= 2'h0;
    repeat (10) @(negedge core_clk);
    x = tw;
    wt(x - 32'h100, n);
    chk({31'h0, n < 3}, 32'h1);
    end_sim();
  end
endmodule : test_drs_ram_profile_sequencer

// ---- hdl/drs_pkg.sv ----
// Shared constants, field layouts and types for the RAM profile sequencer.
package drs_pkg;

  localparam logic [4:0] ADDR_MAIN_CTRL  = 5'h00;
  localparam logic [4:0] ADDR_TUNING0    = 5'h04;
  localparam logic [4:0] ADDR_PHASE_OFS  = 5'h05;
  localparam logic [4:0] ADDR_SEG0       = 5'h07;
  localparam logic [4:0] ADDR_SEG3       = 5'h0a;
  localparam logic [4:0] ADDR_WAVE_MEM   = 5'h0b;

  localparam int unsigned INSTR_READ_BIT = 7;
  localparam int unsigned MEM_ENABLE_BIT = 31;
  localparam int unsigned MEM_DEST_BIT   = 30;
  localparam int unsigned LIN_SWEEP_BIT  = 21;

  localparam logic [31:0] MAIN_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TUNING0_RESET   = 32'h0000_0000;
  localparam logic [13:0] PHASE_OFS_RESET = 14'h0000;
  localparam logic [39:0] SEG_RESET       = 40'h00_0000_0000;

  localparam int unsigned SEG_RATE_LSB  = 24;
  localparam int unsigned SEG_FIN_HI    = 8;
  localparam int unsigned SEG_FIN_LO    = 16;
  localparam int unsigned SEG_BEG_HI    = 0;
  localparam int unsigned SEG_BEG_LO    = 10;
  localparam int unsigned SEG_MODE_LSB  = 5;
  localparam int unsigned SEG_NODWELL   = 4;
  localparam int unsigned SWEEP_RATE_LSB = 32;
  localparam int unsigned MEM_PHASE_LSB  = 18;

  localparam logic [2:0] MODE_DIRECT  = 3'h0;
  localparam logic [2:0] MODE_RAMP_UP = 3'h1;

  localparam int unsigned SYNC_STAGES = 2;

  typedef struct packed {
    logic [15:0] rate;
    logic [9:0]  final_addr;
    logic [9:0]  begin_addr;
    logic [2:0]  mode;
    logic        no_dwell;
  } drs_seg_t;

  // Splits a segment control word into its scattered fields.
  function automatic drs_seg_t drs_seg_decode(input logic [39:0] w);
    drs_seg_t s;
    s.rate       = w[SEG_RATE_LSB +: 16];
    s.final_addr = {w[SEG_FIN_HI +: 2], w[SEG_FIN_LO +: 8]};
    s.begin_addr = {w[SEG_BEG_HI +: 4], w[SEG_BEG_LO +: 6]};
    s.mode       = w[SEG_MODE_LSB +: 3];
    s.no_dwell   = w[SEG_NODWELL];
    return s;
  endfunction : drs_seg_decode

  // Number of data bytes that follow an instruction for each register.
  function automatic logic [2:0] drs_reg_bytes(input logic [4:0] a);
    logic [2:0] n;
    n = 3'h0;
    if (a == ADDR_MAIN_CTRL || a == ADDR_TUNING0 || a == ADDR_WAVE_MEM) n = 3'h4;
    else if (a == ADDR_PHASE_OFS) n = 3'h2;
    else if (a >= ADDR_SEG0 && a <= ADDR_SEG3) n = 3'h5;
    return n;
  endfunction : drs_reg_bytes

endpackage : drs_pkg

// ---- hdl/drs_ram_profile_sequencer.sv ----
// How it works
// - Sweep on: 0x07 falling, 0x08 rising word.
// - Sweep word: 32-bit delta, 8-bit step rate.
// - Sweep off: 0x07..0x0A are segment words.
// - Bits 39:24 dwell count, zero invalid.
// - Final address is bits 9:8 then 23:16.
// - Beginning address is bits 3:0 then 15:10.
// - Bits 7:5 choose the segment mode.
// - No-dwell returns to beginning and holds.
// - Single-port 1024x32 memory, writes win.
// - Memory destination selects offset or accumulator.
// - Unused path takes offset or tuning register.
// - Memory idle when disabled; reset single-tone.
// - Profile pins choose the active segment.
// - Memory writes suspend all memory reads.
// - Memory load fills segment beginning to final.
// - Single-tone uses tuning word zero after update.
// - Direct switch outputs the beginning address word.
// - Profile change never resets the accumulator.
// - Offset use takes memory bits 31:18 only.
// - Ramp up steps address each timer expiry.
// - Ramp up stops at final address.
// - No-dwell clears accumulator one period later.
// - Codes 101 to 111 act as direct switch.
module drs_ram_profile_sequencer
  import drs_pkg::*;
#(
  parameter int unsigned MEM_AW = 10,
  parameter int unsigned MEM_DW = 32
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SDIO,
  input  wire logic        IO_UPDATE,
  input  wire logic [1:0]  PROFILE_SELECT_PINS,
  output logic      [31:0] TUNING_WORD,
  output logic      [13:0] PHASE_OFFSET,
  output logic             PHASE_ACC_CLEAR,
  output logic             MEM_LOAD_BUSY
);

  typedef enum logic [1:0] {
    DRS_IDLE,
    DRS_REG,
    DRS_MEM,
    DRS_SKIP
  } drs_state_t;

  // Link side.
  logic [7:0] rx_byte;
  logic       rx_tgl;

  drs_serial_rx u_rx (
    .sclk       (SCLK),
    .rst        (RST),
    .cs_n       (CS_N),
    .sdio       (SDIO),
    .byte_q     (rx_byte),
    .byte_tgl_q (rx_tgl)
  );

  // Crossings into the core clock; only the second stage is ever looked at.
  logic [SYNC_STAGES-1:0] tgl_sync_q;
  logic [SYNC_STAGES-1:0] cs_sync_q;
  logic [SYNC_STAGES-1:0] upd_sync_q;
  logic [1:0]             ps_meta_q;
  logic [1:0]             ps_q;
  logic                   tgl_seen_q;
  logic                   upd_prev_q;
  logic [1:0]             ps_prev_q;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tgl_sync_q <= '0;
      cs_sync_q  <= '1;
      upd_sync_q <= '0;
      ps_meta_q  <= 2'h0;
      ps_q       <= 2'h0;
      tgl_seen_q <= 1'b0;
      upd_prev_q <= 1'b0;
      ps_prev_q  <= 2'h0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[0], rx_tgl};
      cs_sync_q  <= {cs_sync_q[0], CS_N};
      upd_sync_q <= {upd_sync_q[0], IO_UPDATE};
      ps_meta_q  <= PROFILE_SELECT_PINS;
      ps_q       <= ps_meta_q;
      tgl_seen_q <= tgl_sync_q[1];
      upd_prev_q <= upd_sync_q[1];
      ps_prev_q  <= ps_q;
    end
  end

  logic byte_ev;
  logic frame_off;
  logic upd_ev;
  logic ps_change;
  assign byte_ev   = (tgl_sync_q[1] != tgl_seen_q) && !cs_sync_q[1];
  assign frame_off = cs_sync_q[1];
  assign upd_ev    = upd_sync_q[1] && !upd_prev_q;
  assign ps_change = ps_q != ps_prev_q;

  // Buffered registers written by the port, active copies taken on update.
  logic [31:0] ctrl_buf_q;
  logic [31:0] ctrl_q;
  logic [31:0] tw0_buf_q;
  logic [31:0] tw0_q;
  logic [13:0] pow_buf_q;
  logic [13:0] pow_q;
  logic [39:0] seg_buf_q [4];
  logic [39:0] seg_q [4];

  // Parser state.
  drs_state_t  st_q;
  logic [4:0]  reg_addr_q;
  logic [2:0]  bytes_left_q;
  logic [39:0] shift_q;
  logic [1:0]  word_byte_q;
  logic [9:0]  wr_addr_q;
  logic [9:0]  wr_final_q;
  logic        mem_we_q;
  logic [31:0] mem_wdata_q;
  logic        mem_busy_q;

  drs_seg_t seg_cur;
  assign seg_cur = drs_seg_decode(seg_q[ps_q]);

  logic [39:0] shifted;
  assign shifted = {shift_q[31:0], rx_byte};

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_q         <= DRS_IDLE;
      reg_addr_q   <= 5'h00;
      bytes_left_q <= 3'h0;
      shift_q      <= SEG_RESET;
      word_byte_q  <= 2'h0;
      wr_addr_q    <= 10'h000;
      wr_final_q   <= 10'h000;
      mem_we_q     <= 1'b0;
      mem_wdata_q  <= 32'h0000_0000;
      mem_busy_q   <= 1'b0;
    end else begin
      mem_we_q <= 1'b0;
      if (frame_off) begin
        st_q       <= DRS_IDLE;
        mem_busy_q <= 1'b0;
      end else if (byte_ev) begin
        unique case (st_q)
          DRS_IDLE: begin
            reg_addr_q   <= rx_byte[4:0];
            bytes_left_q <= drs_reg_bytes(rx_byte[4:0]);
            word_byte_q  <= 2'h0;
            // Reads are not answered; the frame is then ignored to its end.
            if (rx_byte[INSTR_READ_BIT] || drs_reg_bytes(rx_byte[4:0]) == 3'h0) begin
              st_q <= DRS_SKIP;
            end else if (rx_byte[4:0] == ADDR_WAVE_MEM) begin
              st_q       <= DRS_MEM;
              mem_busy_q <= 1'b1;
              wr_addr_q  <= seg_cur.begin_addr;
              wr_final_q <= seg_cur.final_addr;
            end else begin
              st_q <= DRS_REG;
            end
          end
          DRS_REG: begin
            shift_q      <= shifted;
            bytes_left_q <= bytes_left_q - 3'h1;
            if (bytes_left_q == 3'h1) begin
              st_q <= DRS_SKIP;
            end
          end
          DRS_MEM: begin
            shift_q     <= shifted;
            word_byte_q <= word_byte_q + 2'h1;
            if (word_byte_q == 2'h3) begin
              mem_we_q    <= 1'b1;
              mem_wdata_q <= shifted[31:0];
              if (wr_addr_q == wr_final_q) begin
                st_q <= DRS_SKIP;
              end
            end
          end
          DRS_SKIP: begin
            st_q <= DRS_SKIP;
          end
        endcase
      end
      if (mem_we_q) begin
        wr_addr_q <= wr_addr_q + 10'h001;
      end
    end
  end

  // A register write lands in its buffer the cycle after its last byte.
  logic reg_done;
  assign reg_done = byte_ev && !frame_off && st_q == DRS_REG && bytes_left_q == 3'h1;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_buf_q <= MAIN_CTRL_RESET;
      tw0_buf_q  <= TUNING0_RESET;
      pow_buf_q  <= PHASE_OFS_RESET;
      for (int i = 0; i < 4; i++) begin
        seg_buf_q[i] <= SEG_RESET;
      end
    end else if (reg_done) begin
      if (reg_addr_q == ADDR_MAIN_CTRL) ctrl_buf_q <= shifted[31:0];
      if (reg_addr_q == ADDR_TUNING0) tw0_buf_q <= shifted[31:0];
      if (reg_addr_q == ADDR_PHASE_OFS) pow_buf_q <= shifted[13:0];
      for (int i = 0; i < 4; i++) begin
        if (reg_addr_q == ADDR_SEG0 + 5'(i)) seg_buf_q[i] <= shifted;
      end
    end
  end

  // Power-up leaves the memory disabled, which is plain single-tone output.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= MAIN_CTRL_RESET;
      tw0_q  <= TUNING0_RESET;
      pow_q  <= PHASE_OFS_RESET;
      for (int i = 0; i < 4; i++) begin
        seg_q[i] <= SEG_RESET;
      end
    end else if (upd_ev) begin
      ctrl_q <= ctrl_buf_q;
      tw0_q  <= tw0_buf_q;
      pow_q  <= pow_buf_q;
      for (int i = 0; i < 4; i++) begin
        seg_q[i] <= seg_buf_q[i];
      end
    end
  end

  logic mem_en;
  logic mem_to_phase;
  logic lin_en;
  logic mem_read;
  assign mem_en       = ctrl_q[MEM_ENABLE_BIT];
  assign mem_to_phase = ctrl_q[MEM_DEST_BIT];
  assign lin_en       = ctrl_q[LIN_SWEEP_BIT];
  assign mem_read     = mem_en && !mem_busy_q && !mem_we_q;

  // Address sequencer.
  logic [9:0]  seq_addr_q;
  logic [15:0] seq_tmr_q;
  logic        seq_done_q;
  logic        acc_clr_q;
  logic        seq_start;
  logic        seq_ramp;
  assign seq_start = upd_ev || ps_change;
  assign seq_ramp  = seg_cur.mode == MODE_RAMP_UP;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      seq_addr_q <= 10'h000;
      seq_tmr_q  <= 16'h0001;
      seq_done_q <= 1'b0;
      acc_clr_q  <= 1'b0;
    end else if (seq_start) begin
      seq_addr_q <= seg_cur.begin_addr;
      seq_tmr_q  <= seg_cur.rate;
      seq_done_q <= 1'b0;
      acc_clr_q  <= 1'b0;
    end else if (!seq_ramp) begin
      seq_addr_q <= seg_cur.begin_addr;
      acc_clr_q  <= 1'b0;
    end else if (mem_read && !seq_done_q) begin
      // A zero rate is not allowed; it is treated like one to keep stepping bounded.
      if (seq_tmr_q > 16'h0001) begin
        seq_tmr_q <= seq_tmr_q - 16'h0001;
      end else begin
        seq_tmr_q <= seg_cur.rate;
        if (seq_addr_q != seg_cur.final_addr) begin
          seq_addr_q <= seq_addr_q + 10'h001;
        end else if (seg_cur.no_dwell) begin
          seq_addr_q <= seg_cur.begin_addr;
          acc_clr_q  <= 1'b1;
          seq_done_q <= 1'b1;
        end else begin
          seq_done_q <= 1'b1;
        end
      end
    end
  end

  logic [31:0] mem_rdata;

  drs_wave_mem #(
    .AW (MEM_AW),
    .DW (MEM_DW)
  ) u_mem (
    .clk   (CORE_CLK),
    .we    (mem_we_q),
    .re    (mem_read),
    .addr  (mem_we_q ? wr_addr_q : seq_addr_q),
    .wdata (mem_wdata_q),
    .rdata (mem_rdata)
  );

  // Linear sweep word generator; direction follows profile pin zero.
  logic [31:0] sweep_q;
  logic [7:0]  sweep_tmr_q;
  logic [31:0] fall_delta;
  logic [7:0]  fall_rate;
  logic [31:0] rise_delta;
  logic [7:0]  rise_rate;
  assign fall_delta = seg_q[0][31:0];
  assign fall_rate  = seg_q[0][SWEEP_RATE_LSB +: 8];
  assign rise_delta = seg_q[1][31:0];
  assign rise_rate  = seg_q[1][SWEEP_RATE_LSB +: 8];

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sweep_q     <= TUNING0_RESET;
      sweep_tmr_q <= 8'h01;
    end else if (upd_ev || !lin_en) begin
      sweep_q     <= upd_ev ? tw0_buf_q : tw0_q;
      sweep_tmr_q <= 8'h01;
    end else if (sweep_tmr_q > 8'h01) begin
      sweep_tmr_q <= sweep_tmr_q - 8'h01;
    end else if (ps_q[0]) begin
      sweep_q     <= sweep_q + rise_delta;
      sweep_tmr_q <= rise_rate;
    end else begin
      sweep_q     <= sweep_q - fall_delta;
      sweep_tmr_q <= fall_rate;
    end
  end

  // Output routing; the accumulator input changes without any reset of the accumulator.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      TUNING_WORD     <= TUNING0_RESET;
      PHASE_OFFSET    <= PHASE_OFS_RESET;
      PHASE_ACC_CLEAR <= 1'b0;
      MEM_LOAD_BUSY   <= 1'b0;
    end else begin
      if (mem_en && !lin_en && !mem_to_phase) begin
        TUNING_WORD <= mem_rdata;
      end else if (lin_en) begin
        TUNING_WORD <= sweep_q;
      end else begin
        TUNING_WORD <= tw0_q;
      end
      if (mem_en && !lin_en && mem_to_phase) begin
        PHASE_OFFSET <= mem_rdata[MEM_PHASE_LSB +: 14];
      end else begin
        PHASE_OFFSET <= pow_q;
      end
      PHASE_ACC_CLEAR <= acc_clr_q && mem_en && !lin_en;
      MEM_LOAD_BUSY   <= mem_busy_q;
    end
  end

endmodule : drs_ram_profile_sequencer

// ---- hdl/drs_serial_rx.sv ----
// Serial shift register on the link clock, handing whole bytes over by toggle.
module drs_serial_rx (
  input  wire logic       sclk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       sdio,
  output logic      [7:0] byte_q,
  output logic            byte_tgl_q
);

  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;

  // Chip select high ends the frame, so no link clock edge is needed to rearm.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= {shift_q[5:0], sdio};
    end
  end

  // The byte holds for eight link clocks, far longer than the core needs to sample it.
  // The core reset parks the toggle at the level the core expects, so no false byte follows.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      byte_q     <= 8'h00;
      byte_tgl_q <= 1'b0;
    end else if (!cs_n && bit_cnt_q == 3'h7) begin
      byte_q     <= {shift_q, sdio};
      byte_tgl_q <= ~byte_tgl_q;
    end
  end

endmodule : drs_serial_rx

// ---- hdl/drs_wave_mem.sv ----
// Single-port waveform memory with registered read data.
module drs_wave_mem #(
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 32
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic          re,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem_q [2**AW];

  // One port only: a write takes the cycle and the read data simply hold.
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end else if (re) begin
      rdata <= mem_q[addr];
    end
  end

endmodule : drs_wave_mem
